// [design/rsc_pkg.sv]
package rsc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned SYSTEM_STARTUP_DELAY_NS = 1000;
  localparam int unsigned SST_CYCLES =
    (SYSTEM_STARTUP_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned HOLD_CYCLES = 4;
  localparam int unsigned CNT_W = 8;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h004;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h008;
  localparam logic [11:0] OFS_CTRL = 12'h00c;

  localparam int unsigned STAT_TO_BIT = 0;
  localparam int unsigned STAT_PDF_BIT = 1;
  localparam int unsigned STAT_MODE_LSB = 2;
  localparam int unsigned STAT_BUSY_BIT = 4;

  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_WDT_RUN = 0;
  localparam int unsigned EV_WDT_LP = 1;
  localparam int unsigned EV_PIN = 2;
  localparam int unsigned EV_LVR = 3;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;

  localparam int unsigned CTRL_LVR_EN_BIT = 0;
  localparam int unsigned CTRL_SWRST_BIT = 1;
  localparam logic CTRL_LVR_EN_RST = 1'b1;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_FAST = 2'b00,
    MODE_SLOW = 2'b01,
    MODE_IDLE = 2'b10,
    MODE_SLEEP = 2'b11
  } rsc_mode_e;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HOLD = 2'b01,
    ST_START = 2'b10
  } rsc_state_e;

  typedef enum logic {
    K_FULL = 1'b0,
    K_WAKE = 1'b1
  } rsc_kind_e;

  typedef struct packed {
    logic core_hold;
    logic pc_clear;
    logic sp_top;
    logic periph_init;
    logic int_disable;
    logic wdt_tb_clear;
    logic tmr_off;
    logic io_input;
    logic fetch_en;
  } rsc_ctl_s;

  typedef struct packed {
    logic watchdog_timeout_flag;
    logic power_down_flag;
  } rsc_flag_s;

  localparam rsc_ctl_s CTL_POR = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
                                   1'b1, 1'b1, 1'b0};

  function automatic logic is_low_power(input rsc_mode_e m);
    return (m == MODE_IDLE) || (m == MODE_SLEEP);
  endfunction

endpackage

// [design/rsc_sync3.sv]
`timescale 1ns/100ps
module rsc_sync3 import rsc_pkg::*; #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  // Pin in, filtered level out
  input wire logic d,
  output logic q
);

  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic q_reg;
  logic q_next;

  // ----------------------------------------
  // Three stages, change once two agree
  // ----------------------------------------
  always_comb begin
    sh_next = sh_reg;
    q_next = q_reg;
    if (ce) begin
      sh_next = {sh_reg[1:0], d};
      if (sh_reg[1] == sh_reg[2]) begin
        q_next = sh_reg[2];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sh_reg <= {3{RST_VAL}};
      q_reg <= RST_VAL;
    end else begin
      sh_reg <= sh_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule

// [design/rsc_delay.sv]
`timescale 1ns/100ps
module rsc_delay import rsc_pkg::*; #(
  parameter int unsigned W = CNT_W,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  // Load and status
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic done
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // ----------------------------------------
  // Down counter, done at zero
  // ----------------------------------------
  always_comb begin
    cnt_next = cnt_reg;
    if (ce) begin
      if (load) begin
        cnt_next = load_val;
      end else if (cnt_reg != '0) begin
        cnt_next = cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= RST_VAL;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg == '0);

endmodule

// [design/rsc_ctrl.sv]
// Notes on behaviour
// - Watchdog expiry in fast or slow mode resets and sets the timeout flag.
// - Watchdog expiry in idle or sleep clears only PC and stack pointer.
// - Power-on clears both flags; low-voltage reset, and pin reset in fast or slow mode, keep them.
// - Watchdog in idle/sleep sets both flags; in run keeps power-down flag.
// - Both flags readable in the status register; sleep and watchdog update.
// - Power-on reset disables every interrupt source.
// - Power-on clears watchdog and time bases; watchdog then counts at once.
// - Power-on reset switches every timer module off.
// - Power-on reset makes every I/O pin an input.
// - Power-on sets program counter to zero, stack pointer to top.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
module rsc_ctrl import rsc_pkg::*; #(
  parameter int unsigned STARTUP_CYCLES = SST_CYCLES,
  parameter int unsigned RESET_HOLD = HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources and mode
  input wire logic reset_pin_b,
  input wire logic low_voltage_reset,
  input wire logic watchdog_timer_expire,
  input wire logic sleep_enter,
  input wire logic flag_clear,
  input wire rsc_mode_e op_mode,
  // Reset controls, flags, interrupt
  output rsc_ctl_s ctl,
  output rsc_flag_s flags,
  output logic irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  rsc_state_e state_reg, state_next;
  rsc_kind_e kind_reg, kind_next;
  rsc_ctl_s ctl_reg, ctl_next;
  rsc_flag_s flag_reg, flag_next;
  logic [EV_W-1:0] ev_reg, ev_next;
  logic [EV_W-1:0] mask_reg, mask_next;
  logic lvr_en_reg, lvr_en_next;
  logic [31:0] rdata_reg, rdata_next;
  logic pin_q;
  logic lp;
  logic acc;
  logic hit;
  logic sw_rst;
  logic pin_rst;
  logic lvr_rst;
  logic wdt_run;
  logic full_req;
  logic wake_req;
  logic dly_load;
  logic [CNT_W-1:0] dly_val;
  logic dly_done;
  logic [EV_W-1:0] ev_set;

  // ----------------------------------------
  // Pin synchroniser and delay counter
  // ----------------------------------------
  rsc_sync3 #(.RST_VAL(1'b1)) u_pin (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .d(reset_pin_b),
    .q(pin_q)
  );

  rsc_delay #(.W(CNT_W), .RST_VAL(CNT_W'(RESET_HOLD))) u_dly (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .load(dly_load),
    .load_val(dly_val),
    .done(dly_done)
  );

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  assign lp = is_low_power(op_mode);
  assign acc = psel && penable;
  assign hit = (paddr == OFS_STATUS) || (paddr == OFS_IRQ_STAT) ||
               (paddr == OFS_IRQ_MASK) || (paddr == OFS_CTRL);
  assign sw_rst = acc && pwrite && (paddr == OFS_CTRL) &&
                  pwdata[CTRL_SWRST_BIT];
  assign pin_rst = !pin_q;
  assign lvr_rst = low_voltage_reset && lvr_en_reg;
  assign wdt_run = watchdog_timer_expire && !lp;
  assign full_req = pin_rst || lvr_rst || sw_rst || wdt_run;
  assign wake_req = watchdog_timer_expire && lp && !full_req &&
                    (state_reg == ST_RUN);
  assign ev_set = {lvr_rst, pin_rst, watchdog_timer_expire && lp, wdt_run};

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    dly_load = 1'b0;
    dly_val = CNT_W'(RESET_HOLD);
    if (ce) begin
      if (full_req) begin
        state_next = ST_HOLD;
        kind_next = K_FULL;
        dly_load = 1'b1;
      end else if (wake_req) begin
        state_next = ST_HOLD;
        kind_next = K_WAKE;
        dly_load = 1'b1;
      end else begin
        case (state_reg)
          ST_HOLD: begin
            if (dly_done) begin
              state_next = ST_START;
              dly_load = 1'b1;
              dly_val = CNT_W'(STARTUP_CYCLES);
            end
          end
          ST_START: begin
            if (dly_done) begin
              state_next = ST_RUN;
            end
          end
          default: state_next = state_reg;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Core and peripheral controls
  // ----------------------------------------
  always_comb begin
    ctl_next = ctl_reg;
    if (ce) begin
      ctl_next.core_hold = (state_next != ST_RUN);
      ctl_next.fetch_en = (state_next == ST_RUN);
      ctl_next.pc_clear = (state_next == ST_HOLD);
      ctl_next.sp_top = (state_next == ST_HOLD);
      ctl_next.periph_init = (state_next == ST_HOLD) &&
                             (kind_next == K_FULL);
      ctl_next.int_disable = ctl_next.periph_init;
      ctl_next.wdt_tb_clear = ctl_next.periph_init;
      ctl_next.tmr_off = ctl_next.periph_init;
      ctl_next.io_input = ctl_next.periph_init;
    end
  end

  // ----------------------------------------
  // Flags, clear first so sets win
  // ----------------------------------------
  always_comb begin
    flag_next = flag_reg;
    if (ce) begin
      if (flag_clear) begin
        flag_next = '0;
      end
      if (sleep_enter) begin
        flag_next.power_down_flag = 1'b1;
        flag_next.watchdog_timeout_flag = 1'b0;
      end
      if (pin_rst && lp) begin
        flag_next.watchdog_timeout_flag = 1'b0;
        flag_next.power_down_flag = 1'b1;
      end
      if (watchdog_timer_expire) begin
        flag_next.watchdog_timeout_flag = 1'b1;
        if (lp) begin
          flag_next.power_down_flag = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_comb begin
    ev_next = ev_reg;
    mask_next = mask_reg;
    lvr_en_next = lvr_en_reg;
    rdata_next = rdata_reg;
    if (ce) begin
      if (psel && !penable) begin
        rdata_next = '0;
        case (paddr)
          OFS_STATUS: begin
            rdata_next[STAT_TO_BIT] = flag_reg.watchdog_timeout_flag;
            rdata_next[STAT_PDF_BIT] = flag_reg.power_down_flag;
            rdata_next[STAT_MODE_LSB +: 2] = op_mode;
            rdata_next[STAT_BUSY_BIT] = (state_reg != ST_RUN);
          end
          OFS_IRQ_STAT: rdata_next[EV_W-1:0] = ev_reg;
          OFS_IRQ_MASK: rdata_next[EV_W-1:0] = mask_reg;
          OFS_CTRL: rdata_next[CTRL_LVR_EN_BIT] = lvr_en_reg;
          default: rdata_next = '0;
        endcase
      end
      if (acc && !pwrite && (paddr == OFS_IRQ_STAT)) begin
        ev_next = ev_reg & ~rdata_reg[EV_W-1:0];
      end
      if (acc && pwrite && (paddr == OFS_IRQ_MASK)) begin
        mask_next = pwdata[EV_W-1:0];
      end
      if (acc && pwrite && (paddr == OFS_CTRL)) begin
        lvr_en_next = pwdata[CTRL_LVR_EN_BIT];
      end
      ev_next = ev_next | ev_set;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_HOLD;
      kind_reg <= K_FULL;
      ctl_reg <= CTL_POR;
      flag_reg <= '0;
      ev_reg <= '0;
      mask_reg <= IRQ_MASK_RST;
      lvr_en_reg <= CTRL_LVR_EN_RST;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      ctl_reg <= ctl_next;
      flag_reg <= flag_next;
      ev_reg <= ev_next;
      mask_reg <= mask_next;
      lvr_en_reg <= lvr_en_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign ctl = ctl_reg;
  assign flags = flag_reg;
  assign irq = |(ev_reg & mask_reg);
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata = rdata_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic first_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_wdt_run_flag: assert property (
    ce && wdt_run |=> flags.watchdog_timeout_flag && ctl.core_hold &&
    ctl.periph_init)
    else $error("run watchdog reset missing");
  a_wake_partial: assert property (
    ce && wake_req |=> ctl.pc_clear && ctl.sp_top && !ctl.periph_init &&
    !ctl.tmr_off)
    else $error("wake reset not partial");
  a_por_flags_clear: assert property (
    first_reg |-> flags == '0 && ctl.periph_init)
    else $error("power-on flags not clear");
  a_pin_flags_keep: assert property (
    ce && pin_rst && !lp && !watchdog_timer_expire && !sleep_enter &&
    !flag_clear |=> flags == $past(flags))
    else $error("pin reset changed flags");
  a_lp_flags_set: assert property (
    ce && watchdog_timer_expire && lp |=> flags == 2'b11)
    else $error("low-power watchdog flags wrong");
  a_status_read: assert property (
    psel && !penable && ce && paddr == OFS_STATUS |=>
    prdata[STAT_TO_BIT] == $past(flags.watchdog_timeout_flag) &&
    prdata[STAT_PDF_BIT] == $past(flags.power_down_flag))
    else $error("status read wrong");
  a_full_init: assert property (
    ctl.periph_init |-> ctl.int_disable && ctl.tmr_off && ctl.io_input &&
    ctl.pc_clear && ctl.sp_top && ctl.wdt_tb_clear)
    else $error("full reset controls incomplete");
  a_wdt_counts: assert property (
    state_reg == ST_START |-> !ctl.wdt_tb_clear)
    else $error("watchdog held in start-up");
  a_pc_every: assert property (
    state_reg == ST_HOLD |-> ctl.pc_clear)
    else $error("program counter not cleared");
  a_start_wait: assert property (
    ce && state_reg == ST_HOLD && state_next == ST_START && !full_req |=>
    !ctl.fetch_en [*8])
    else $error("fetch before start-up delay");

  c_wake: cover property (ce && wake_req);
  c_pin: cover property (ce && pin_rst && state_reg == ST_RUN);
  c_resume: cover property ($rose(ctl.fetch_en));
  c_irq: cover property ($rose(irq));

endmodule

// [dv/rsc_core_model.sv]
`timescale 1ns/100ps
module rsc_core_model import rsc_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Reset controls
  input wire rsc_ctl_s ctl,
  // Core state
  output logic [15:0] pc,
  output logic [3:0] sp
);
  logic [15:0] pc_next;
  logic [3:0] sp_next;

  // ----------------------------------------
  // Fetch and stack state
  // ----------------------------------------
  always_comb begin
    pc_next = pc;
    sp_next = sp;
    if (ctl.pc_clear) begin
      pc_next = 16'h0000;
    end else if (ctl.fetch_en && !ctl.core_hold) begin
      pc_next = pc + 16'h0001;
    end
    if (ctl.sp_top) begin
      sp_next = 4'h0;
    end else if (ctl.fetch_en) begin
      sp_next = sp + 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pc <= 16'h0000;
      sp <= 4'h0;
    end else begin
      pc <= pc_next;
      sp <= sp_next;
    end
  end
endmodule

// [dv/tb_reset_state_controller.sv]
`timescale 1ns/100ps
module tb_reset_state_controller import rsc_pkg::*;;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic reset_pin_b = 1'b1, low_voltage_reset = 1'b0;
  logic watchdog_timer_expire = 1'b0, sleep_enter = 1'b0;
  logic flag_clear = 1'b0;
  logic ce = 1'b1;
  rsc_mode_e op_mode = MODE_FAST;
  rsc_ctl_s ctl;
  rsc_flag_s flags;
  logic [15:0] pc;
  logic [3:0] sp;
  logic [31:0] exp_q[$];
  logic [31:0] m;
  int bad_count = 0, checks_done = 0;
  localparam logic [31:0] WAKE = 32'h1c0;

  always #12.5 clock = ~clock;

  rsc_ctrl #(.STARTUP_CYCLES(8), .RESET_HOLD(4)) DUT (.clock(clock),
    .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_pin_b(reset_pin_b),
    .low_voltage_reset(low_voltage_reset),
    .watchdog_timer_expire(watchdog_timer_expire),
    .sleep_enter(sleep_enter), .flag_clear(flag_clear),
    .op_mode(op_mode), .ctl(ctl), .flags(flags), .irq(irq));

  rsc_core_model core (.clock(clock), .rst_b(rst_b), .ctl(ctl),
    .pc(pc), .sp(sp));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) begin
        chk("read without note", 32'h1, 32'h0);
      end else begin
        chk("prdata", exp_q.pop_front(), prdata);
      end
    end
  end

  // ----------------------------------------
  // Bus and event drivers
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] e,
                     input logic err);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) exp_q.push_back(e);
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("pready wait", 32'h1, 32'h0);
      print_verdict();
    end
    chk("pslverr", 32'(err), 32'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ev(input int k);
    @(posedge clock);
    case (k)
      0: watchdog_timer_expire <= 1'b1;
      1: sleep_enter <= 1'b1;
      default: flag_clear <= 1'b1;
    endcase
    @(posedge clock);
    watchdog_timer_expire <= 1'b0;
    sleep_enter <= 1'b0;
    flag_clear <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic wait_run();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (ctl.fetch_en !== 1'b1 && n < 300);
    if (n >= 300) begin
      chk("fetch wait", 32'h1, 32'h0);
      print_verdict();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(22337));
    repeat (5) @(posedge clock);
    #1;
    chk("ctl por", 32'(CTL_POR), 32'(ctl));
    chk("flags por", 32'h0, 32'(flags));
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    wait_run();
    apb(1'b0, OFS_STATUS, 32'h0, 32'h0, 1'b0);
    apb(1'b0, OFS_IRQ_MASK, 32'h0, 32'h0, 1'b0);
    apb(1'b0, OFS_CTRL, 32'h0, 32'h1, 1'b0);
    m = 32'($urandom & 32'hf);
    apb(1'b1, OFS_IRQ_MASK, m, 32'h0, 1'b0);
    apb(1'b0, OFS_IRQ_MASK, 32'h0, m, 1'b0);
    apb(1'b1, OFS_IRQ_MASK, 32'h2, 32'h0, 1'b0);
    ev(1);
    chk("flags sleep", 32'h1, 32'(flags));
    op_mode <= MODE_SLEEP;
    ev(0);
    chk("ctl wake", WAKE, 32'(ctl));
    chk("flags wake", 32'h3, 32'(flags));
    chk("pc wake", 32'h0, 32'(pc));
    chk("sp wake", 32'h0, 32'(sp));
    chk("irq raised", 32'h1, 32'(irq));
    wait_run();
    apb(1'b0, OFS_STATUS, 32'h0, 32'h0f, 1'b0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0, 32'h2, 1'b0);
    @(posedge clock);
    #1;
    chk("irq cleared", 32'h0, 32'(irq));
    op_mode <= MODE_FAST;
    ev(2);
    chk("flags clear", 32'h0, 32'(flags));
    ev(1);
    ev(0);
    chk("ctl run wdt", 32'(CTL_POR), 32'(ctl));
    chk("flags run wdt", 32'h3, 32'(flags));
    chk("irq masked", 32'h0, 32'(irq));
    wait_run();
    apb(1'b0, OFS_IRQ_STAT, 32'h0, 32'h1, 1'b0);
    op_mode <= MODE_SLOW;
    @(posedge clock);
    reset_pin_b <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    chk("ctl pin", 32'(CTL_POR), 32'(ctl));
    chk("flags pin", 32'h3, 32'(flags));
    reset_pin_b <= 1'b1;
    wait_run();
    @(posedge clock);
    low_voltage_reset <= 1'b1;
    repeat (2) @(posedge clock);
    low_voltage_reset <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("flags lvr", 32'h3, 32'(flags));
    wait_run();
    apb(1'b0, OFS_IRQ_STAT, 32'h0, 32'hc, 1'b0);
    apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h3, 32'h0, 1'b0);
    repeat (2) @(posedge clock);
    #1;
    chk("ctl soft", 32'(CTL_POR), 32'(ctl));
    wait_run();
    apb(1'b0, OFS_CTRL, 32'h0, 32'h1, 1'b0);
    op_mode <= MODE_IDLE;
    @(posedge clock);
    reset_pin_b <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    chk("ctl pin idle", 32'(CTL_POR), 32'(ctl));
    chk("flags pin idle", 32'h1, 32'(flags));
    reset_pin_b <= 1'b1;
    wait_run();
    ce <= 1'b0;
    flag_clear <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk("flags frozen", 32'h1, 32'(flags));
    chk("fetch frozen", 32'h1, 32'(ctl.fetch_en));
    ce <= 1'b1;
    flag_clear <= 1'b0;
    repeat (2) @(posedge clock);
    print_verdict();
  end
endmodule
